// ### rtl/connection_mgmt_state_command.sv
// Command decode for the connection state machine and insertion scrubbing
`include "conn_mgmt_map.svh"

// Summary of operation
// [RULE_01] Zero command leaves state untouched
// [RULE_02] Decode 01 break, 10 trace, 11 off
// [RULE_03] Start and stop act from any state
// [RULE_04] Trace only honoured while active
// [RULE_05] Zero write re-arms start command
// [RULE_06] Self-entered break waits for start
// [RULE_07] Start or stop while inserted triggers scrubbing
// [RULE_08] Running scrub finishes before break/off
// [RULE_09] Off with maintenance request goes maintenance
// [RULE_10] Field holds value; new nonzero write triggers
module connection_mgmt_state_command
    import conn_mgmt_pkg::*;
#(
    parameter int SCRUB_NS = `CMC_SCRUB_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`CMC_ADDR_W-1:0] addr,
    input wire logic [`CMC_DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [`CMC_DATA_W-1:0] rdData,
    input wire logic autoBreak,
    input wire logic stepAdvance,
    output conn_state_t connState,
    output ins_state_t insState,
    output logic scrubbing
);

    // ------------------------------------------------------------
    // Timing derived from the clock period
    // ------------------------------------------------------------
    // Least scrub time, so round the cycle count up
    localparam int SCRUB_CYC_RAW =
        (SCRUB_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS;
    localparam int SCRUB_CYCLES = (SCRUB_CYC_RAW < 1) ? 1 : SCRUB_CYC_RAW;

    // ------------------------------------------------------------
    // Control register state
    // ------------------------------------------------------------
    cmd_t cmdField; // Last written command value
    logic maintReq; // Maintenance request bit
    logic startArmed; // Start allowed since last zero write
    logic breakLatch; // Break was entered without a command
    logic pendValid; // Start/stop waiting on scrubbing
    cmd_t pendCmd; // Which of start/stop is waiting

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire wrCtrl = wrStrobe && (addr == `CMC_ADDR_CTRL_B);
    wire rdCtrl = rdStrobe && (addr == `CMC_ADDR_CTRL_B);
    wire rdStat = rdStrobe && (addr == `CMC_ADDR_STATUS);
    wire cmd_t cmdWrite = wrData[`CMC_CMD_MSB:`CMC_CMD_LSB];

    // A zero write never forces anything; it re-arms start and makes the next nonzero write count as new
    wire cmdZeroWr = wrCtrl && (cmdWrite == `CMC_CMD_HOLD); // RULE_01

    // New command: nonzero value that differs from the held one,
    // or any nonzero value after the field went back to zero
    wire cmdNew = wrCtrl && (cmdWrite != `CMC_CMD_HOLD) &&
        ((cmdField == `CMC_CMD_HOLD) || (cmdWrite != cmdField)); // RULE_10

    // Decode of the three forcing values
    wire startReq = cmdNew && (cmdWrite == `CMC_CMD_START) &&
        startArmed; // RULE_02 RULE_05
    wire stopReq = cmdNew && (cmdWrite == `CMC_CMD_STOP); // RULE_02
    wire traceReq = cmdNew && (cmdWrite == `CMC_CMD_TRACE) &&
        (connState == CONN_ACTIVE); // RULE_02 RULE_04

    // ------------------------------------------------------------
    // Start/stop arbitration against insertion scrubbing
    // ------------------------------------------------------------
    // The latest start or stop wins over a waiting one
    wire effValid = startReq || stopReq || pendValid;
    wire cmd_t effCmd = (startReq || stopReq) ? cmdWrite : pendCmd;

    // Force only once insertion has settled in the removed state
    wire insIdle = (insState == INS_REMOVED);
    wire apply = effValid && insIdle; // RULE_08
    wire applyStart = apply && (effCmd == `CMC_CMD_START); // RULE_03
    wire applyStop = apply && (effCmd == `CMC_CMD_STOP); // RULE_03

    // Autonomous break is taken only from the running states
    wire autoTake = autoBreak &&
        (connState != CONN_OFF) && (connState != CONN_MAINT) &&
        (connState != CONN_BREAK);

    // ------------------------------------------------------------
    // Scrub timer
    // ------------------------------------------------------------
    logic timerStart; // Pulse on entry into either scrub state
    logic scrubDone; // Pulse when the interval has elapsed
    logic timerBusy; // Interval running

    scrub_timer #(
        .CYCLES(SCRUB_CYCLES)
    ) u_scrub_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(timerStart),
        .busy(timerBusy),
        .done(scrubDone)
    );

    // ------------------------------------------------------------
    // Connection state machine next state
    // ------------------------------------------------------------
    conn_state_t next_connState;

    always_comb begin
        next_connState = connState;
        if (applyStop) begin
            // Straight past OFF into maintenance when requested
            next_connState = maintReq ? CONN_MAINT : CONN_OFF; // RULE_09
        end else if (applyStart) begin
            next_connState = CONN_BREAK; // RULE_03
        end else if (traceReq) begin
            next_connState = CONN_TRACE; // RULE_04
        end else if (autoTake) begin
            next_connState = CONN_BREAK; // RULE_06
        end else begin
            case (connState)
                CONN_OFF: begin
                    // Maintenance request acts as soon as OFF is seen
                    if (maintReq) begin
                        next_connState = CONN_MAINT; // RULE_09
                    end
                end
                CONN_BREAK: begin
                    // Held here after a break not caused by a start
                    if (!breakLatch) begin
                        next_connState = CONN_CONNECT; // RULE_06
                    end
                end
                CONN_CONNECT: begin
                    if (stepAdvance) begin
                        next_connState = CONN_NEXT;
                    end
                end
                CONN_NEXT: begin
                    if (stepAdvance) begin
                        next_connState = CONN_ACTIVE;
                    end
                end
                CONN_ACTIVE: begin
                    next_connState = CONN_ACTIVE;
                end
                CONN_TRACE: begin
                    next_connState = CONN_TRACE;
                end
                CONN_MAINT: begin
                    next_connState = CONN_MAINT;
                end
                default: begin
                    // Illegal code recovers to the safe state
                    next_connState = CONN_OFF;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Insertion state machine next state
    // ------------------------------------------------------------
    ins_state_t next_insState;
    wire connUp = (connState == CONN_ACTIVE) ||
        (connState == CONN_TRACE);

    always_comb begin
        next_insState = insState;
        case (insState)
            INS_REMOVED: begin
                // Insert only while up and nothing is waiting
                if (connUp && !effValid && !autoTake) begin
                    next_insState = INS_SCRUB;
                end
            end
            INS_SCRUB: begin
                // A waiting command ends in REMOVED, not INSERTED
                if (scrubDone) begin
                    next_insState = effValid ? INS_REMOVED
                                             : INS_IN; // RULE_08
                end
            end
            INS_IN: begin
                // Start or stop while inserted scrubs on removal
                if (effValid || !connUp || autoTake) begin
                    next_insState = REM_SCRUB; // RULE_07
                end
            end
            REM_SCRUB: begin
                if (scrubDone) begin
                    next_insState = INS_REMOVED; // RULE_08
                end
            end
            default: begin
                next_insState = INS_REMOVED;
            end
        endcase
    end

    // Timer starts on entry into a scrub state only
    assign timerStart = (next_insState != insState) &&
        ((next_insState == INS_SCRUB) || (next_insState == REM_SCRUB));
    assign scrubbing = timerBusy;

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            connState <= CONN_OFF;
            insState <= INS_REMOVED;
        end else begin
            connState <= next_connState;
            insState <= next_insState;
        end
    end

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    // The field keeps whatever software wrote, forcing or not
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdField <= `CMC_CMD_HOLD;
            maintReq <= 1'b0;
        end else if (wrCtrl) begin
            cmdField <= cmdWrite; // RULE_10
            maintReq <= wrData[`CMC_MAINT_BIT];
        end
    end

    // ------------------------------------------------------------
    // Start re-arm
    // ------------------------------------------------------------
    // Accepted start disarms; only a zero write arms again
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startArmed <= 1'b1;
        end else if (cmdZeroWr) begin
            startArmed <= 1'b1; // RULE_05
        end else if (startReq) begin
            startArmed <= 1'b0; // RULE_05
        end
    end

    // ------------------------------------------------------------
    // Break hold after autonomous entry
    // ------------------------------------------------------------
    // An applied start or stop releases the hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            breakLatch <= 1'b0;
        end else if (applyStart || applyStop) begin
            breakLatch <= 1'b0;
        end else if (autoTake) begin
            breakLatch <= 1'b1; // RULE_06
        end
    end

    // ------------------------------------------------------------
    // Command waiting on scrubbing
    // ------------------------------------------------------------
    // Held rather than dropped; only a later start or stop replaces it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pendValid <= 1'b0;
            pendCmd <= `CMC_CMD_HOLD;
        end else begin
            pendValid <= effValid && !apply; // RULE_08
            pendCmd <= effCmd;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Status view of both machines and the internal flags
    logic [`CMC_DATA_W-1:0] statusWord;

    always_comb begin
        statusWord = `CMC_RST_DATA;
        statusWord[`CMC_ST_CONN_MSB:`CMC_ST_CONN_LSB] = connState;
        statusWord[`CMC_ST_INS_MSB:`CMC_ST_INS_LSB] = insState;
        statusWord[`CMC_ST_LATCH_BIT] = breakLatch;
        statusWord[`CMC_ST_PEND_BIT] = pendValid;
        statusWord[`CMC_ST_ARMED_BIT] = startArmed;
    end

    // Control readback: command field and maintenance bit
    logic [`CMC_DATA_W-1:0] ctrlWord;

    always_comb begin
        ctrlWord = `CMC_RST_DATA;
        ctrlWord[`CMC_CMD_MSB:`CMC_CMD_LSB] = cmdField;
        ctrlWord[`CMC_MAINT_BIT] = maintReq;
    end

    wire [`CMC_DATA_W-1:0] rdSel = rdCtrl ? ctrlWord :
        rdStat ? statusWord : `CMC_RST_DATA;

    // Data stand one cycle after the strobe and are zero otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= `CMC_RST_DATA;
        end else begin
            rdData <= rdSel;
        end
    end

endmodule

// ### include/conn_mgmt_map.svh
// Register map, field positions, codes and timing of connection control
`ifndef CONN_MGMT_MAP_SVH
`define CONN_MGMT_MAP_SVH

// ----------------------------------------------------------------
// Register addresses (byte addresses on the plain port)
// ----------------------------------------------------------------
`define CMC_ADDR_W 8
`define CMC_ADDR_CTRL_B 8'h00
`define CMC_ADDR_STATUS 8'h04
`define CMC_DATA_W 16

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMC_CMD_LSB 0
`define CMC_CMD_MSB 1
`define CMC_MAINT_BIT 2
`define CMC_ST_CONN_LSB 0
`define CMC_ST_CONN_MSB 6
`define CMC_ST_INS_LSB 8
`define CMC_ST_INS_MSB 11
`define CMC_ST_LATCH_BIT 12
`define CMC_ST_PEND_BIT 13
`define CMC_ST_ARMED_BIT 14

// ----------------------------------------------------------------
// Command codes and reset values
// ----------------------------------------------------------------
`define CMC_CMD_HOLD 2'h0
`define CMC_CMD_START 2'h1
`define CMC_CMD_TRACE 2'h2
`define CMC_CMD_STOP 2'h3
`define CMC_RST_DATA 16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CMC_CLK_NS 40
`define CMC_SCRUB_NS 3500

`endif

// ### include/conn_mgmt_pkg.sv
// Types shared by the connection management command logic
package conn_mgmt_pkg;

    // Connection management states, one-hot
    typedef enum logic [6:0] {
        CONN_OFF     = 7'b0000001,
        CONN_BREAK   = 7'b0000010,
        CONN_TRACE   = 7'b0000100,
        CONN_CONNECT = 7'b0001000,
        CONN_NEXT    = 7'b0010000,
        CONN_ACTIVE  = 7'b0100000,
        CONN_MAINT   = 7'b1000000
    } conn_state_t;

    // Insertion states, one-hot
    typedef enum logic [3:0] {
        INS_REMOVED = 4'b0001,
        INS_SCRUB   = 4'b0010,
        INS_IN      = 4'b0100,
        REM_SCRUB   = 4'b1000
    } ins_state_t;

    // Command field values
    typedef logic [1:0] cmd_t;

endpackage

// ### rtl/scrub_timer.sv
// Down-counter that times one scrubbing interval
module scrub_timer #(
    parameter int CYCLES = 88
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    output logic busy,
    output logic done
);

    localparam int W = (CYCLES > 1) ? $clog2(CYCLES + 1) : 1;
    localparam logic [W-1:0] LOAD = W'(CYCLES);
    localparam logic [W-1:0] ONE = W'(1);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [W-1:0] count; // Cycles left in the interval
    wire lastTick = busy && (count == ONE); // Final cycle of interval

    // Restart on start, even mid-count, so intervals never overlap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= lastTick && !start;
            if (start) begin
                count <= LOAD;
                busy <= 1'b1;
            end else if (lastTick) begin
                count <= '0;
                busy <= 1'b0;
            end else if (busy) begin
                count <= count - ONE;
            end
        end
    end

endmodule

// ### verif/node_processor.sv
// Node processor model that drives the control register port
`include "conn_mgmt_map.svh"
module node_processor (
    input wire logic clk,
    output logic [`CMC_ADDR_W-1:0] addr,
    output logic [`CMC_DATA_W-1:0] wrData,
    output logic wrStrobe,
    output logic rdStrobe,
    input wire logic [`CMC_DATA_W-1:0] rdData
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus: strobes low from time zero
    initial begin
        addr = 8'h00;
        wrData = 16'h0000;
        wrStrobe = 1'h0;
        rdStrobe = 1'h0;
    end
    // One-cycle write; released lines show the inverse so stale data is
    // never mistaken for a held value
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'h1;
        @(posedge clk);
        wrStrobe <= 1'h0;
        addr <= ~a;
        wrData <= ~d;
        #1;
    endtask
    // One-cycle read; data taken only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'h1;
        @(posedge clk);
        rdStrobe <= 1'h0;
        addr <= ~a;
        #1 d = rdData;
    endtask
endmodule

// ### verif/conn_cmd_props.sv
// Port-level assertions for the connection command block
`include "conn_mgmt_map.svh"
module conn_cmd_props
    import conn_mgmt_pkg::*;
#(
    parameter int SCRUB_NS = `CMC_SCRUB_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`CMC_ADDR_W-1:0] addr,
    input wire logic [`CMC_DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [`CMC_DATA_W-1:0] rdData,
    input wire logic autoBreak,
    input wire logic stepAdvance,
    input wire conn_state_t connState,
    input wire ins_state_t insState,
    input wire logic scrubbing
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Shadow of what software last wrote
    // ------------------------------------------------------------
    logic [1:0] cmdReg; // Stored command field
    logic maintReg; // Stored maintenance request
    logic armed; // Start may be taken
    logic heldBreak; // Break entered without software
    wire ctrlWr = wrStrobe && addr == `CMC_ADDR_CTRL_B;
    wire [1:0] cmd = wrData[`CMC_CMD_MSB:`CMC_CMD_LSB];
    wire startNew = ctrlWr && cmd == `CMC_CMD_START && armed;
    wire stopNew = ctrlWr && cmd == `CMC_CMD_STOP && cmdReg != cmd;
    wire traceNew = ctrlWr && cmd == `CMC_CMD_TRACE && cmdReg != cmd;
    wire cmdNew = startNew || stopNew;
    wire linked = connState inside {CONN_CONNECT, CONN_NEXT, CONN_ACTIVE,
        CONN_TRACE};
    wire scrubState = insState inside {INS_SCRUB, REM_SCRUB};
    // Shadow follows each control write; a write beats the line event
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdReg <= 2'h0;
            maintReg <= 1'h0;
            armed <= 1'h1;
            heldBreak <= 1'h0;
        end else if (ctrlWr) begin
            cmdReg <= cmd;
            maintReg <= wrData[`CMC_MAINT_BIT];
            armed <= cmd == `CMC_CMD_HOLD || (armed && !startNew);
            heldBreak <= heldBreak && !cmdNew;
        end else if (autoBreak && linked) begin
            heldBreak <= 1'h1;
        end
    end
    // ------------------------------------------------------------
    // Multi-step outcomes
    // ------------------------------------------------------------
    sequence offThenMaint;
        connState == CONN_OFF ##1 connState == CONN_MAINT;
    endsequence
    sequence scrubThenMove;
        ##[0:200] insState == INS_REMOVED ##1
            connState inside {CONN_BREAK, CONN_OFF};
    endsequence
    // A zero command in MAINT or while inserted leaves the state where it is
    hold_cmd_a: assert property (
        ctrlWr && cmd == `CMC_CMD_HOLD && !autoBreak &&
        (connState == CONN_MAINT || insState == INS_IN)
        |=> $stable(connState))
        else $error("state moved on a zero command");
    start_break_a: assert property (
        startNew && insState == INS_REMOVED |=> connState == CONN_BREAK)
        else $error("start did not break");
    stop_off_a: assert property (
        stopNew && !wrData[`CMC_MAINT_BIT] && !maintReg &&
        insState == INS_REMOVED |=> connState == CONN_OFF)
        else $error("stop did not reach off");
    stop_maint_a: assert property (
        stopNew && wrData[`CMC_MAINT_BIT] && !maintReg &&
        insState == INS_REMOVED |=> offThenMaint)
        else $error("off did not pass to maintenance");
    trace_taken_a: assert property (
        traceNew && connState == CONN_ACTIVE && !autoBreak
        |=> connState == CONN_TRACE) else $error("trace lost");
    trace_ignored_a: assert property (
        traceNew && (connState == CONN_MAINT || (connState == CONN_OFF &&
        !wrData[`CMC_MAINT_BIT] && !maintReg)) |=> $stable(connState))
        else $error("trace honoured outside active");
    auto_break_a: assert property (
        autoBreak && linked && !ctrlWr |=> connState == CONN_BREAK)
        else $error("line event missed");
    break_held_a: assert property (
        heldBreak && connState == CONN_BREAK && !ctrlWr
        |=> connState == CONN_BREAK) else $error("break left alone");
    scrub_start_a: assert property (
        cmdNew && insState == INS_IN |=> insState == REM_SCRUB)
        else $error("no scrub from inserted");
    scrub_first_a: assert property (
        cmdNew && scrubState && linked && !autoBreak
        |=> !(connState inside {CONN_BREAK, CONN_OFF})
        until insState == INS_REMOVED)
        else $error("state moved before scrub end");
    scrub_then_a: assert property (
        cmdNew && !wrData[`CMC_MAINT_BIT] && insState != INS_REMOVED
        |=> scrubThenMove) else $error("command not applied after scrub");
    field_read_a: assert property (
        rdStrobe && addr == `CMC_ADDR_CTRL_B
        |=> rdData == {13'h0000, maintReg, cmdReg})
        else $error("field lost");
endmodule

bind connection_mgmt_state_command conn_cmd_props #(.SCRUB_NS(SCRUB_NS)) props (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .autoBreak(autoBreak), .stepAdvance(stepAdvance),
    .connState(connState), .insState(insState), .scrubbing(scrubbing)
);

// ### verif/tb_top.sv
// Directed tests of the connection command block
`include "conn_mgmt_map.svh"
module tb_top
    import conn_mgmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CTRL = `CMC_ADDR_CTRL_B;
    localparam logic [7:0] STAT = `CMC_ADDR_STATUS;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic autoBreak = 1'h0;
    logic stepAdvance = 1'h0;
    logic [7:0] addr;
    logic [15:0] wrData, rdData, rd;
    logic wrStrobe, rdStrobe, scrubbing;
    conn_state_t connState;
    ins_state_t insState;
    int mismatches = 0;
    int compares = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    node_processor cpu (.clk(clk), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData));
    // Short scrub (10 cycles) keeps the run brief
    connection_mgmt_state_command #(.SCRUB_NS(400)) dut (.clk(clk),
        .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .autoBreak(autoBreak),
        .stepAdvance(stepAdvance), .connState(connState),
        .insState(insState), .scrubbing(scrubbing));
    // ------------------------------------------------------------
    // Compare and wait helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cs(input conn_state_t e);
        check(16'(connState), 16'(e));
    endtask
    task automatic conclude;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Bounded waits; a miss shows in the compare that follows
    task automatic waitConn(input conn_state_t s);
        for (int n = 0; n < 40 && connState !== s; n++) @(posedge clk) #1;
    endtask
    task automatic waitIns(input ins_state_t s);
        for (int n = 0; n < 40 && insState !== s; n++) @(posedge clk) #1;
    endtask
    // Two steps: connect to next to active
    task automatic advance;
        @(posedge clk);
        stepAdvance <= 1'h1;
        repeat (2) @(posedge clk);
        stepAdvance <= 1'h0;
        #1;
    endtask
    // Watchdog: the tests need well under 20 us
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        cpu.rd(CTRL, rd);
        check(rd, 16'h0000);
        cpu.rd(STAT, rd);
        check(rd, 16'h4101);
        // Read data stand one cycle only, then fall back to zero
        @(posedge clk) #1 check(rdData, 16'h0000);
        cpu.wr(8'h10, 16'h0003);
        cs(CONN_OFF);
        cpu.rd(8'h10, rd);
        check(rd, 16'h0000);
        cpu.wr(CTRL, 16'h0002);
        cs(CONN_OFF);
        cpu.rd(CTRL, rd);
        check(rd, 16'h0002);
        cpu.wr(CTRL, 16'h0001);
        cs(CONN_BREAK);
        waitConn(CONN_CONNECT);
        cs(CONN_CONNECT);
        cpu.wr(CTRL, 16'h0000);
        cs(CONN_CONNECT);
        // Line event in connect: break must latch
        @(posedge clk) autoBreak <= 1'h1;
        @(posedge clk) autoBreak <= 1'h0;
        repeat (4) @(posedge clk);
        #1 cs(CONN_BREAK);
        cpu.rd(STAT, rd);
        check(rd & 16'h1000, 16'h1000);
        cpu.wr(CTRL, 16'h0001);
        waitConn(CONN_CONNECT);
        cs(CONN_CONNECT);
        cpu.wr(CTRL, 16'h0003);
        cs(CONN_OFF);
        cpu.wr(CTRL, 16'h0001);
        cs(CONN_OFF);
        cpu.wr(CTRL, 16'h0000);
        cpu.wr(CTRL, 16'h0001);
        cs(CONN_BREAK);
        // Stop while the insertion_scrub_state runs
        waitConn(CONN_CONNECT);
        advance();
        waitIns(INS_SCRUB);
        cpu.wr(CTRL, 16'h0003);
        cs(CONN_ACTIVE);
        check(16'(scrubbing), 16'h0001);
        waitIns(INS_REMOVED);
        cs(CONN_ACTIVE);
        @(posedge clk) #1 cs(CONN_OFF);
        // Trace then stop while inserted
        cpu.wr(CTRL, 16'h0000);
        cpu.wr(CTRL, 16'h0001);
        waitConn(CONN_CONNECT);
        advance();
        waitIns(INS_IN);
        cpu.wr(CTRL, 16'h0002);
        cs(CONN_TRACE);
        cpu.wr(CTRL, 16'h0003);
        check(16'(insState), 16'(REM_SCRUB));
        waitIns(INS_REMOVED);
        cs(CONN_TRACE);
        @(posedge clk) #1 cs(CONN_OFF);
        // Stop with maintenance request
        cpu.wr(CTRL, 16'h0000);
        cpu.wr(CTRL, 16'h0001);
        waitConn(CONN_CONNECT);
        cpu.wr(CTRL, 16'h0007);
        cs(CONN_OFF);
        @(posedge clk) #1 cs(CONN_MAINT);
        cpu.wr(CTRL, 16'h0006);
        cs(CONN_MAINT);
        cpu.wr(CTRL, 16'h0004);
        cs(CONN_MAINT);
        conclude();
    end
endmodule
